// ### rtl/ssr_mode_ctl.sv
// Behaviour
// R1 - reselection answered with BSY only when reselection-response bit is set
// R2 - selection answered with BSY only when selection-response bit is set
// R3 - auto receive, message-in phase error: await ATN off, one message, ACK held
// R4 - auto receive, status phase error: one status, ACK per release mode
// R5 - no auto receive: report initial phase error, after negating ATN
// R6 - error while receiving status reports error with phase error step
// R7 - phase error mid transfer always reports in-progress code
// R8 - ATN at final ACK: auto receive takes message, else complete-ATN
// R9 - command ending in message out reports complete-ATN regardless
// R10 - ATN at boundary: stop at block, auto receive takes message
// R11 - DMA or processor parity block stop wins over attention
// R12 - second attention after auto message reports 61H, step plus one
// R13 - received bytes stored from 0, or after CDB for command phase
// R14 - data parity error: byte stop or block stop, odd count per two
// R15 - single initiator accepts own bit alone, nexus ID 000
// R16 - initiator drives own and target ID bits during selection
// R17 - arbitration bit set skips arbitration
// R18 - user program bit starts execution at low seven bit address
// R19 - auto reselection runs to message, else reports reselected
// R20 - auto selection runs to message or command, else selected report
// R21 - post-selection bit forces message out, no ATN is phase error
// R22 - auto reselection steps 0, 1, then 2
// R23 - mode settings take effect only at the setup command
`default_nettype none
module ssr_mode_ctl
  import ssr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // bus events from the protocol engine
  input  wire logic        resel_det,
  input  wire logic        sel_det,
  input  wire logic [7:0]  sel_id_bits,
  input  wire logic        sel_atn,
  input  wire logic        sel_start,
  input  wire logic [2:0]  self_id,
  input  wire logic [2:0]  target_id,
  input  wire logic        byte_rx,
  input  wire logic        rx_error,
  input  wire logic        bus_free,
  // initiator phase error
  input  wire logic        ini_phase_err,
  input  wire logic        pe_msg_in,
  input  wire logic        xfer_busy,
  input  wire logic        own_atn,
  input  wire logic        ack_release,
  input  wire logic [7:0]  cur_step,
  // target attention and parity
  input  wire logic        atn_final_ack,
  input  wire logic        atn_boundary,
  input  wire logic        cmd_ends_mo,
  input  wire logic        cmd_phase,
  input  wire logic [6:0]  cdb_len,
  input  wire logic        dma_par_err,
  input  wire logic        mpu_par_err,
  input  wire logic        data_par_err,
  input  wire logic        block_end,
  input  wire logic        odd_count,
  // decisions
  output logic             bsy_assert,
  output logic             skip_arb,
  output logic [7:0]       sel_id_out,
  output logic             user_go,
  output logic [6:0]       user_addr,
  output logic             negate_atn,
  output logic             goto_msg_out,
  output logic             stop_xfer,
  output logic             hold_ack,
  output logic             rx_we,
  output logic [6:0]       rx_addr,
  output logic [2:0]       nexus_id,
  output logic             report,
  output logic [7:0]       int_code,
  output logic [7:0]       int_step
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ssr_state_t  st;
    logic [7:0]  stg_rsp, stg_sel, act_rsp, act_sel;
    logic [7:0]  code, step, pre_step, ids;
    logic [6:0]  ptr, rxa, uaddr;
    logic [2:0]  nid;
    logic        rpt, bsy, ugo, neg, gmo, stp, hack, we, arb;
    logic        pe_msg, par_pend, blk_odd, awg, wg, bv, rv;
    logic        awr, wr, arr;
    logic [7:0]  awa;
    logic [7:0]  wd;
    logic        ws;
    logic [1:0]  br, rr;
    logic [31:0] rd;
  } ssr_state_s_t;

  ssr_state_s_t s_r, s_nxt;

  // single decode shared by the read and write paths
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == A_RSP_MODE) || (a == A_SEL_MODE) || (a == A_CONTROL) ||
             (a == A_STATUS) || (a == A_ACTIVE);
  endfunction

  function automatic logic [3:0] ones(input logic [7:0] v);
    ones = 4'h0;
    for (int i = 0; i < 8; i++) begin
      ones = ones + {3'h0, v[i]};
    end
  endfunction

  logic       wr_go, setup_go, id_ok, one_bit, auto_rx;
  logic [7:0] own_bit;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rpt = 1'b0;
    s_nxt.bsy = 1'b0;
    s_nxt.ugo = 1'b0;
    s_nxt.we  = 1'b0;
    s_nxt.gmo = 1'b0;
    s_nxt.stp = 1'b0;
    s_nxt.neg = 1'b0;
    auto_rx  = s_r.act_rsp[B_AUTO_RX];
    own_bit  = 8'h01 << self_id;
    one_bit  = ones(sel_id_bits) == 4'h1;
    id_ok    = (sel_id_bits & own_bit) != 8'h00 &&
               (ones(sel_id_bits) == 4'h2 || (s_r.act_rsp[B_SINGLE] && one_bit)); // [R15]
    // axi write: address and data taken in either order
    if (s_axi_awvalid && s_r.awr) begin
      s_nxt.awg = 1'b1;
      s_nxt.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wr) begin
      s_nxt.wg = 1'b1;
      s_nxt.wd = s_axi_wdata[7:0];
      s_nxt.ws = s_axi_wstrb[0];
    end
    wr_go    = s_r.awg && s_r.wg && !s_r.bv;
    setup_go = 1'b0;
    if (wr_go) begin
      s_nxt.awg = 1'b0;
      s_nxt.wg  = 1'b0;
      s_nxt.bv  = 1'b1;
      s_nxt.br  = mapped(s_r.awa) ? RESP_OK : RESP_SLVERR;
      if (s_r.ws) begin
        if (s_r.awa == A_RSP_MODE) begin
          s_nxt.stg_rsp = s_r.wd;
        end
        if (s_r.awa == A_SEL_MODE) begin
          s_nxt.stg_sel = s_r.wd;
        end
        setup_go = s_r.awa == A_CONTROL && s_r.wd[B_CTL_SETUP];
      end
    end
    if (s_r.bv && s_axi_bready) begin
      s_nxt.bv = 1'b0;
    end
    // axi read: one outstanding, answered the cycle after it is taken
    if (s_r.rv && s_axi_rready) begin
      s_nxt.rv = 1'b0;
    end
    if (s_axi_arvalid && s_r.arr) begin
      s_nxt.rv = 1'b1;
      s_nxt.rr = mapped(s_axi_araddr) ? RESP_OK : RESP_SLVERR;
      case (s_axi_araddr)
        A_RSP_MODE: s_nxt.rd = {24'h0, s_r.stg_rsp};
        A_SEL_MODE: s_nxt.rd = {24'h0, s_r.stg_sel};
        A_STATUS:   s_nxt.rd = {13'h0, s_r.st, s_r.step, s_r.code};
        A_ACTIVE:   s_nxt.rd = {16'h0, s_r.act_sel, s_r.act_rsp};
        default:    s_nxt.rd = 32'h0;
      endcase
    end
    // setup loads staged modes; refused while an automatic sequence runs
    if (setup_go) begin
      s_nxt.rpt  = 1'b1;
      s_nxt.step = 8'h00;
      if (s_r.st == ST_IDLE) begin
        s_nxt.act_rsp = s_r.stg_rsp; // [R23]
        s_nxt.act_sel = s_r.stg_sel; // [R23]
        s_nxt.code    = C_CMD_DONE;  // [R23]
      end else begin
        s_nxt.code = C_CMD_REJ;
      end
    end
    s_nxt.arb   = s_r.act_rsp[B_NO_ARB]; // [R17]
    s_nxt.uaddr = s_r.act_sel[6:0];
    if (sel_start) begin
      s_nxt.ids = own_bit | (8'h01 << target_id); // [R16]
    end
    // byte-unit or block-unit stop on a data parity error
    if (data_par_err) begin
      if (s_r.act_rsp[B_PAR_BYTE]) begin
        s_nxt.stp = 1'b1; // [R14]
        s_nxt.rpt = 1'b1;
        s_nxt.code = C_DATA_PAR;
      end else begin
        s_nxt.par_pend = 1'b1;
      end
    end
    if (block_end) begin
      s_nxt.blk_odd = odd_count && !s_r.blk_odd;
      if (s_r.par_pend && !(odd_count && !s_r.blk_odd)) begin
        // an error in the same cycle re-arms the stop for the next block
        s_nxt.par_pend = data_par_err && !s_r.act_rsp[B_PAR_BYTE]; // [R14]
        s_nxt.stp  = 1'b1;
        s_nxt.rpt  = 1'b1;
        s_nxt.code = C_DATA_PAR;
      end
    end
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.ptr = 7'h00; // [R13]
        if (resel_det && s_r.act_rsp[B_RESEL_RSP]) begin
          s_nxt.bsy = 1'b1; // [R1]
          if (s_r.act_sel[B_USER_PROG]) begin
            s_nxt.ugo = 1'b1; // [R18]
          end else if (s_r.act_sel[B_AUTO_RSL]) begin
            s_nxt.st   = ST_RESEL_RX; // [R19]
            s_nxt.step = 8'h00;       // [R22]
          end else begin
            s_nxt.rpt  = 1'b1;
            s_nxt.code = C_RESELECTED; // [R19]
            s_nxt.step = 8'h00;
          end
        end else if (sel_det && s_r.act_rsp[B_SEL_RSP] && id_ok) begin
          s_nxt.bsy = 1'b1; // [R2]
          s_nxt.nid = (s_r.act_rsp[B_SINGLE] && one_bit) ? 3'h0 : target_id; // [R15]
          if (s_r.act_sel[B_USER_PROG]) begin
            s_nxt.ugo = 1'b1; // [R18]
          end else if (s_r.act_sel[B_POST_MO] && !sel_atn) begin
            s_nxt.rpt  = 1'b1;
            s_nxt.code = C_AUTO_PE; // [R21]
          end else if (s_r.act_sel[B_AUTO_SEL]) begin
            s_nxt.st = ST_SEL_RX; // [R20]
            s_nxt.gmo = sel_atn;  // [R21]
          end else begin
            s_nxt.rpt  = 1'b1;
            s_nxt.code = sel_atn ? C_SEL_ATN : C_SELECTED; // [R20]
          end
        end else if (ini_phase_err) begin
          s_nxt.pe_msg = pe_msg_in;
          s_nxt.step   = cur_step;
          if (xfer_busy) begin
            s_nxt.rpt  = 1'b1;
            s_nxt.code = C_PE_XFER; // [R7]
          end else begin
            s_nxt.neg = own_atn;     // [R5]
            s_nxt.st  = ST_PE_ATN;
          end
        end else if (atn_final_ack || atn_boundary) begin
          s_nxt.pre_step = cur_step;
          s_nxt.ptr  = cmd_phase ? cdb_len : 7'h00; // [R13]
          s_nxt.stp  = atn_boundary;                // [R10]
          if (atn_boundary && (dma_par_err || mpu_par_err)) begin
            s_nxt.rpt  = 1'b1;
            s_nxt.code = dma_par_err ? C_DMA_PAR : C_MPU_PAR; // [R11]
          end else if (atn_final_ack && cmd_ends_mo) begin
            s_nxt.rpt  = 1'b1;
            s_nxt.code = C_CC_ATN; // [R9]
          end else if (auto_rx) begin
            s_nxt.gmo  = 1'b1; // [R8] [R10]
            s_nxt.st   = ST_TGT_RX;
            s_nxt.code = atn_final_ack ? C_CC_ATN_MSG : C_CS_ATN_MSG;
          end else begin
            s_nxt.rpt  = 1'b1;
            s_nxt.code = atn_final_ack ? C_CC_ATN : C_CS_ATN; // [R8] [R10]
          end
        end
      end
      ST_RESEL_RX: begin
        s_nxt.step = byte_rx ? 8'h02 : 8'h01; // [R22]
        if (byte_rx) begin
          s_nxt.we   = 1'b1;
          s_nxt.rxa  = s_r.ptr;
          s_nxt.rpt  = 1'b1;
          s_nxt.code = C_RESEL_MSG;
          s_nxt.st   = ST_IDLE;
        end
      end
      ST_SEL_RX: begin
        if (byte_rx) begin
          s_nxt.we   = 1'b1;
          s_nxt.rxa  = s_r.ptr;
          s_nxt.rpt  = 1'b1;
          s_nxt.code = C_SEL_AUTO; // [R20]
          s_nxt.st   = ST_IDLE;
        end
      end
      ST_PE_ATN: begin
        // the message or status waits for our own ATN to fall
        s_nxt.neg = own_atn; // [R3]
        if (!own_atn) begin
          if (auto_rx) begin
            s_nxt.st = ST_PE_RX;
          end else begin
            s_nxt.rpt  = 1'b1;
            s_nxt.code = C_PE_INIT; // [R5]
            s_nxt.st   = ST_IDLE;
          end
        end
      end
      ST_PE_RX: begin
        if (rx_error && !s_r.pe_msg) begin
          s_nxt.rpt  = 1'b1;
          s_nxt.code = C_RX_ERR; // [R6]
          s_nxt.st   = ST_IDLE;
        end else if (byte_rx) begin
          s_nxt.we   = 1'b1;
          s_nxt.rxa  = s_r.ptr; // [R13]
          s_nxt.rpt  = 1'b1;
          s_nxt.code = s_r.pe_msg ? C_PE_MSG : C_PE_STS;  // [R3] [R4]
          s_nxt.hack = s_r.pe_msg || !ack_release;      // [R3] [R4]
          s_nxt.st   = ST_IDLE;
        end
      end
      ST_TGT_RX: begin
        if (byte_rx) begin
          s_nxt.we  = 1'b1;
          s_nxt.rxa = s_r.ptr; // [R13]
          s_nxt.rpt = 1'b1;
          s_nxt.st  = ST_TGT_POST;
        end
      end
      ST_TGT_POST: begin
        if (atn_final_ack || atn_boundary) begin
          s_nxt.rpt  = 1'b1;
          s_nxt.code = C_ATN_AGAIN;          // [R12]
          s_nxt.step = s_r.pre_step + 8'h01; // [R12]
          s_nxt.st   = ST_IDLE;
        end else if (bus_free) begin
          s_nxt.st = ST_IDLE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    if (s_r.we) begin
      s_nxt.ptr = s_r.ptr + 7'h01;
    end
    // a hold taken in this very cycle outlives a same-cycle release
    if ((bus_free || sel_start) && !(s_r.st == ST_PE_RX && s_nxt.we)) begin
      s_nxt.hack = 1'b0;
    end
    // readies from the next state so every output is a flop
    s_nxt.awr = !s_nxt.awg && !s_nxt.bv;
    s_nxt.wr  = !s_nxt.wg && !s_nxt.bv;
    s_nxt.arr = !s_nxt.rv;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r         <= '0;
      s_r.st      <= ST_IDLE;
      s_r.stg_rsp <= RST_MODE;
      s_r.stg_sel <= RST_MODE;
      s_r.act_rsp <= RST_MODE;
      s_r.act_sel <= RST_MODE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs, each a field of the state register
  assign s_axi_awready = s_r.awr;
  assign s_axi_wready  = s_r.wr;
  assign s_axi_bvalid  = s_r.bv;
  assign s_axi_bresp   = s_r.br;
  assign s_axi_arready = s_r.arr;
  assign s_axi_rvalid  = s_r.rv;
  assign s_axi_rdata   = s_r.rd;
  assign s_axi_rresp   = s_r.rr;
  assign bsy_assert    = s_r.bsy;
  assign skip_arb      = s_r.arb;
  assign sel_id_out    = s_r.ids;
  assign user_go       = s_r.ugo;
  assign user_addr     = s_r.uaddr;
  assign negate_atn    = s_r.neg;
  assign goto_msg_out  = s_r.gmo;
  assign stop_xfer     = s_r.stp;
  assign hold_ack      = s_r.hack;
  assign rx_we         = s_r.we;
  assign rx_addr       = s_r.rxa;
  assign nexus_id      = s_r.nid;
  assign report        = s_r.rpt;
  assign int_code      = s_r.code;
  assign int_step      = s_r.step;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_resel_ignore: assert property (s_r.st == ST_IDLE && resel_det &&
    !s_r.act_rsp[B_RESEL_RSP] |=> !bsy_assert) else $error("bsy on ignored resel"); // [R1]
  a_sel_ignore: assert property (s_r.st == ST_IDLE && sel_det && !resel_det &&
    !s_r.act_rsp[B_SEL_RSP] |=> !bsy_assert) else $error("bsy on ignored sel"); // [R2]
  a_setup_load: assert property (wr_go && s_r.ws && s_r.awa == A_CONTROL &&
    s_r.wd[B_CTL_SETUP] && s_r.st == ST_IDLE
    |=> report && int_code == C_CMD_DONE && s_r.act_rsp == $past(s_r.stg_rsp))
    else $error("setup did not load modes"); // [R23]
  a_pe_xfer: assert property (s_r.st == ST_IDLE && ini_phase_err && xfer_busy &&
    !resel_det && !sel_det |=> report && int_code == C_PE_XFER)
    else $error("in-transfer phase error code wrong"); // [R7]
  a_atn_again: assert property (s_r.st == ST_TGT_POST && atn_final_ack
    |=> int_code == 8'h61 && int_step == $past(s_r.pre_step) + 8'h01)
    else $error("second attention report wrong"); // [R12]
  a_pe_msg_ack: assert property (report && int_code == C_PE_MSG |-> hold_ack)
    else $error("ack released after msg phase error"); // [R3]
  a_par_byte: assert property (data_par_err && s_r.act_rsp[B_PAR_BYTE]
    |=> stop_xfer && report) else $error("byte stop missing"); // [R14]
  a_resel_steps: assert property (s_r.st == ST_IDLE && resel_det &&
    s_r.act_rsp[B_RESEL_RSP] && s_r.act_sel[7:6] == 2'b01 && !setup_go
    |=> int_step == 8'h00 ##1 int_step == 8'h01) else $error("resel steps wrong"); // [R22]
  a_single_id: assert property (s_r.st == ST_IDLE && !resel_det && sel_det &&
    s_r.act_rsp[B_SEL_RSP] && s_r.act_rsp[B_SINGLE] && sel_id_bits == own_bit
    |=> bsy_assert && nexus_id == 3'h0) else $error("single initiator select"); // [R15]
  a_arb_follow: assert property ($changed(s_r.act_rsp[B_NO_ARB])
    |=> skip_arb == $past(s_r.act_rsp[B_NO_ARB])) else $error("arb skip stale"); // [R17]

  c_auto_resel: cover property (s_r.st == ST_RESEL_RX ##1 report);
  c_pe_status:  cover property (report && int_code == C_PE_STS);
  c_atn_again:  cover property (report && int_code == C_ATN_AGAIN);
  c_block_stop: cover property (s_r.par_pend ##[1:20] stop_xfer);

endmodule
`default_nettype wire

// ### rtl/ssr_pkg.sv
`default_nettype none
package ssr_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_RSP_MODE = 8'h00;
  localparam logic [7:0] A_SEL_MODE = 8'h04;
  localparam logic [7:0] A_CONTROL  = 8'h08;
  localparam logic [7:0] A_STATUS   = 8'h0C;
  localparam logic [7:0] A_ACTIVE   = 8'h10;
  localparam logic [7:0] RST_MODE   = 8'h00;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int B_RESEL_RSP = 7;
  localparam int B_SEL_RSP   = 6;
  localparam int B_AUTO_RX   = 5;
  localparam int B_PAR_BYTE  = 4;
  localparam int B_SINGLE    = 1;
  localparam int B_NO_ARB    = 0;
  localparam int B_USER_PROG = 7;
  localparam int B_AUTO_RSL  = 6;
  localparam int B_AUTO_SEL  = 5;
  localparam int B_POST_MO   = 4;
  localparam int B_CTL_SETUP = 0;
  // ----------------------------------------------------------------
  // interrupt codes
  // ----------------------------------------------------------------
  localparam logic [7:0] C_CMD_DONE  = 8'h10;
  localparam logic [7:0] C_CMD_REJ   = 8'h11;
  localparam logic [7:0] C_RESELECTED= 8'h20;
  localparam logic [7:0] C_RESEL_MSG = 8'h21;
  localparam logic [7:0] C_SELECTED  = 8'h22;
  localparam logic [7:0] C_SEL_ATN   = 8'h23;
  localparam logic [7:0] C_SEL_AUTO  = 8'h24;
  localparam logic [7:0] C_AUTO_PE   = 8'h25;
  localparam logic [7:0] C_PE_INIT   = 8'h30;
  localparam logic [7:0] C_PE_MSG    = 8'h31;
  localparam logic [7:0] C_PE_STS    = 8'h32;
  localparam logic [7:0] C_PE_XFER   = 8'h33;
  localparam logic [7:0] C_RX_ERR    = 8'h34;
  localparam logic [7:0] C_CC_ATN    = 8'h40;
  localparam logic [7:0] C_CC_ATN_MSG= 8'h41;
  localparam logic [7:0] C_CS_ATN    = 8'h42;
  localparam logic [7:0] C_CS_ATN_MSG= 8'h43;
  localparam logic [7:0] C_DMA_PAR   = 8'h50;
  localparam logic [7:0] C_MPU_PAR   = 8'h51;
  localparam logic [7:0] C_DATA_PAR  = 8'h52;
  localparam logic [7:0] C_ATN_AGAIN = 8'h61;
  localparam logic [1:0] RESP_OK     = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_RESEL_RX, ST_SEL_RX, ST_PE_ATN, ST_PE_RX, ST_TGT_RX, ST_TGT_POST
  } ssr_state_t;
endpackage
`default_nettype wire

// ### verification/ssr_bus_peer.sv
`default_nettype none
module ssr_bus_peer (
  // clock, reset and bench requests
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       resel_go,
  input  wire logic       pe_go,
  input  wire logic       pe_busy,
  input  wire logic [3:0] msg_dly,
  // events seen on the bus
  output logic            resel_det,
  output logic            byte_rx,
  output logic            ini_phase_err,
  output logic            xfer_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  // target reselects, then sends one message in after a chosen delay
  always @(posedge clk_sys) begin
    resel_det     <= resel_go & rst_n;
    ini_phase_err <= pe_go & rst_n;
    xfer_busy     <= pe_go & pe_busy; // bytes outstanding only with the error
    byte_rx       <= (cnt_r == 4'h1);
    if (!rst_n) begin
      cnt_r <= 4'h0;
    end else if (resel_go) begin
      cnt_r <= msg_dly;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### verification/test_scsi_selection_response_modes.sv
`default_nettype none
module test_scsi_selection_response_modes
  import ssr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------
  // signals and instances
  // ---------------------------------------------
  logic        clk_sys = 1'b0, rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        resel_det, byte_rx, ini_phase_err, xfer_busy;
  // events not made by the peer, which only reselects, sends one message in and raises phase errors
  logic        sel_det = 1'b0, sel_atn = 1'b0, sel_start = 1'b0, rx_error = 1'b0;
  logic        bus_free = 1'b0, pe_msg_in = 1'b0, own_atn = 1'b0, ack_release = 1'b0;
  logic        atn_final_ack = 1'b0, atn_boundary = 1'b0, cmd_ends_mo = 1'b0;
  logic        cmd_phase = 1'b0, dma_par_err = 1'b0, mpu_par_err = 1'b0;
  logic        data_par_err = 1'b0, block_end = 1'b0, odd_count = 1'b0;
  logic [7:0]  sel_id_bits = 8'h00, cur_step = 8'h00;
  logic [2:0]  self_id = 3'h0, target_id = 3'h0;
  logic [6:0]  cdb_len = 7'h00;
  logic        bsy_assert, skip_arb, user_go, negate_atn, goto_msg_out, stop_xfer;
  logic        hold_ack, rx_we, report;
  logic [7:0]  sel_id_out, int_code, int_step;
  logic [6:0]  user_addr, rx_addr;
  logic [2:0]  nexus_id;
  logic        resel_go = 1'b0, pe_go = 1'b0, pe_busy = 1'b0;
  logic [3:0]  msg_dly = 4'h6;
  int          mismatches = 0, samples_checked = 0, nbsy = 0;

  ssr_mode_ctl ssr_mode_ctl_i (.*);
  ssr_bus_peer ssr_bus_peer_i (.*);

  initial forever #50 clk_sys = ~clk_sys;
  // count busy answers so an unwanted one is never missed
  always @(posedge clk_sys) if (bsy_assert === 1'b1) nbsy <= nbsy + 1;
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // a wait that used its whole bound ends the run
  task automatic tmo(input int n);
    if (n >= 50) begin
      mismatches++;
      close_out();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  task automatic kick(input bit pe);
    @(posedge clk_sys);
    if (pe) pe_go <= 1'b1;
    else resel_go <= 1'b1;
    @(posedge clk_sys);
    pe_go    <= 1'b0;
    resel_go <= 1'b0;
  endtask
  task automatic wait_rep(output logic [7:0] c, output logic [7:0] s);
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (report === 1'b1) break;
    end
    c = int_code;
    s = int_step;
    tmo(n);
  endtask
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  c, s;
    int          n;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(A_RSP_MODE, d, r);
    chk(d, 32'h0);
    rd(8'h14, d, r);
    chk(r, RESP_SLVERR);
    // selection seen with the response bit clear, and our own selection start
    self_id   <= 3'h2;
    target_id <= 3'h5;
    sel_det   <= 1'b1;
    sel_start <= 1'b1;
    @(posedge clk_sys);
    sel_det   <= 1'b0;
    sel_start <= 1'b0;
    kick(1'b0);
    repeat (10) @(posedge clk_sys);
    chk(nbsy, 32'h0);
    chk(sel_id_out, 8'h24);
    $display("test reset and ignored reselection done");
    axw(A_RSP_MODE, 32'h81, r);
    axw(A_SEL_MODE, 32'h40, r);
    rd(A_ACTIVE, d, r);
    chk(d, 32'h0);
    chk(skip_arb, 1'b0);
    axw(A_CONTROL, 32'h1, r);
    // the completion pulse stands in the cycle in which bvalid is seen
    chk({report, int_code}, {1'b1, C_CMD_DONE});
    chk(r, RESP_OK);
    rd(A_ACTIVE, d, r);
    chk(d, 32'h4081);
    chk(skip_arb, 1'b1);
    $display("test setup command done");
    kick(1'b0);
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (bsy_assert === 1'b1) break;
    end
    tmo(n);
    chk(int_step, 8'h00);
    @(posedge clk_sys);
    chk(int_step, 8'h01);
    wait_rep(c, s);
    chk(c, C_RESEL_MSG);
    chk(s, 8'h02);
    chk({rx_we, rx_addr}, {1'b1, 7'h00});
    chk(nbsy, 32'h1);
    $display("test automatic reselection done");
    pe_busy <= 1'b1;
    kick(1'b1);
    wait_rep(c, s);
    chk(c, C_PE_XFER);
    pe_busy <= 1'b0;
    kick(1'b1);
    wait_rep(c, s);
    chk(c, C_PE_INIT);
    $display("test phase errors done");
    // target side: single initiator selection, byte stop, attention at final ack
    axw(A_RSP_MODE, 32'h52, r);
    axw(A_CONTROL, 32'h1, r);
    chk({report, int_code}, {1'b1, C_CMD_DONE});
    sel_id_bits <= 8'h04;
    sel_det     <= 1'b1;
    @(posedge clk_sys);
    sel_det <= 1'b0;
    wait_rep(c, s);
    chk(c, C_SELECTED);
    chk({bsy_assert, nexus_id}, 4'h8);
    data_par_err <= 1'b1;
    @(posedge clk_sys);
    data_par_err <= 1'b0;
    wait_rep(c, s);
    chk({stop_xfer, c}, {1'b1, C_DATA_PAR});
    atn_final_ack <= 1'b1;
    @(posedge clk_sys);
    atn_final_ack <= 1'b0;
    wait_rep(c, s);
    chk(c, C_CC_ATN);
    $display("test target selection, parity and attention done");
    close_out();
  end
endmodule
`default_nettype wire
